// ---- pkg/chan_ctrl_consts.svh ----
// register indices, field positions, masks and reset values of the channel control bank
`ifndef CHAN_CTRL_CONSTS_SVH
`define CHAN_CTRL_CONSTS_SVH
// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define IDX_GEN       8'h00
`define IDX_TST       8'h01
`define IDX_RT        8'h02
`define IDX_BIPEN     8'h03
`define IDX_RSV4      8'h04
`define IDX_BIPSTS    8'h98
`define IDX_BIPCLR    8'h99
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define GEN_CRC_DIS   3
`define GEN_SOP       4
`define GEN_FAB_LB    5
`define GEN_SER_LB    6
`define GEN_LSM       7
`define TST_PRBS_EN   1
`define TST_PRBS_LOCK 2
`define TST_TX_REV    4
`define TST_TX_INV    5
`define TST_RX_REV    6
`define TST_RX_INV    7
`define RT_TC_RX      6
`define RT_TC_TX      7
// ---------------------------------------------------------------
// masks, reset values, fixed codes
// ---------------------------------------------------------------
`define GEN_MASK      8'hf8
`define TST_MASK      8'hf6
`define RT_MASK       8'hc0
`define BIPEN_MASK    8'hff
`define REG_RST       8'h00
`define CV_DATA       8'hee
`define BYTE_ZERO     8'h00
`define WORD_ZERO     32'h0000_0000
`define ADDR_HI_ZERO  2'h0
`define ADDR_LO_ZERO  2'h0
`endif

// ---- pkg/chan_ctrl_pkg.sv ----
// types shared by the channel control bank
package chan_ctrl_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [2:0] {
    SEL_NONE  = 3'b000,
    SEL_GEN   = 3'b001,
    SEL_TST   = 3'b010,
    SEL_RT    = 3'b011,
    SEL_BIPEN = 3'b100,
    SEL_RSV   = 3'b101,
    SEL_STS   = 3'b110,
    SEL_CLR   = 3'b111
  } reg_sel_t;
endpackage

// ---- logic/bit_condition.sv ----
// bit-order reversal and inversion of one parallel data word
`timescale 1ns/10ps
`default_nettype none
module bit_condition (
  input  wire logic [7:0] data_in,
  input  wire logic       reverse,
  input  wire logic       invert,
  output logic      [7:0] data_out
);
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      assign data_out[i] = (reverse ? data_in[7 - i] : data_in[i]) ^ invert;
    end
  endgenerate
endmodule
`default_nettype wire

// ---- logic/bip_irq.sv ----
// sticky parity error flags, write-one clear and the level interrupt
`timescale 1ns/10ps
`default_nettype none
`include "chan_ctrl_consts.svh"
module bip_irq (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  input  wire logic [7:0] event_in,
  input  wire logic [7:0] clear,
  input  wire logic [7:0] enable,
  output logic      [7:0] status,
  output logic            irq
);
  logic [7:0] status_q;
  logic [7:0] status_d;
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_flag
      // set wins over clear so an error in the clear cycle is kept
      assign status_d[i] = event_in[i] | (status_q[i] & ~clear[i]);
    end
  endgenerate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= `REG_RST;
    end else if (ce) begin
      status_q <= status_d;
    end
  end
  assign status = status_q;
  assign irq    = |(status_q & enable);
endmodule
`default_nettype wire

// ---- logic/chan_ctrl_regs.sv ----
// channel general control register bank with data path controls
// ---------------------------------------------------------------
// Overview of operation
// - receive crc logic off when crc-disable and packet-marker mode both set
// - marker mode puts packet start on violation port, else violations as k with ee
// - fabric-bridge loopback returns receive data into the transmit path
// - serializer-bridge loopback feeds transmit data into the receive path
// - link state machine runs only while its enable bit is one
// - one bit enables the prbs generator and checker together
// - one bit locks the receive prbs checker, zero unlocks it
// - transmit data bit order reversed when set
// - every transmitted data bit inverted when set
// - receive data bit order reversed when set
// - every received data bit inverted when set
// - receive outputs shown on test pins; quad test mode also needed
// - transmit coding takes inputs from test ports when set
// - eight enable bits gate the section parity error interrupts
// ---------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "chan_ctrl_consts.svh"
module chan_ctrl_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  tx_data_in,
  input  wire logic        tx_k_in,
  input  wire logic [7:0]  tc_tx_data_in,
  input  wire logic        tc_tx_k_in,
  output logic      [7:0]  ser_tx_data,
  output logic             ser_tx_k,
  input  wire logic [7:0]  ser_rx_data,
  input  wire logic        ser_rx_k,
  input  wire logic        rx_cv_in,
  input  wire logic        rx_sop_in,
  output logic      [7:0]  rx_data,
  output logic             rx_k,
  output logic             rx_cv_port,
  output logic      [7:0]  tc_rx_data,
  output logic             tc_rx_k,
  output logic             crc_enable,
  output logic             link_sm_enable,
  output logic             prbs_enable,
  output logic             prbs_lock,
  input  wire logic [7:0]  bip_error,
  output logic             irq
);
  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  chan_ctrl_pkg::byte_t     gen_q;
  chan_ctrl_pkg::byte_t     tst_q;
  chan_ctrl_pkg::byte_t     rt_q;
  chan_ctrl_pkg::byte_t     bipen_q;
  chan_ctrl_pkg::byte_t     bip_status;
  chan_ctrl_pkg::reg_sel_t  sel;
  logic [31:0]              prdata_q;
  logic [31:0]              rd_word;
  logic [7:0]               idx;
  logic                     aligned;
  logic                     setup;
  logic                     access;
  logic                     wr_en;
  logic                     wr_lane0;
  logic [7:0]               bip_clr;
  wire  logic [7:0]         wbyte;

  assign idx      = paddr[9:2];
  assign aligned  = (paddr[11:10] == `ADDR_HI_ZERO) && (paddr[1:0] == `ADDR_LO_ZERO);
  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign wbyte    = pwdata[7:0];
  assign wr_lane0 = pstrb[0];

  always_comb begin
    sel = chan_ctrl_pkg::SEL_NONE;
    if (aligned) begin
      case (idx)
        `IDX_GEN:    sel = chan_ctrl_pkg::SEL_GEN;
        `IDX_TST:    sel = chan_ctrl_pkg::SEL_TST;
        `IDX_RT:     sel = chan_ctrl_pkg::SEL_RT;
        `IDX_BIPEN:  sel = chan_ctrl_pkg::SEL_BIPEN;
        `IDX_RSV4:   sel = chan_ctrl_pkg::SEL_RSV;
        `IDX_BIPSTS: sel = chan_ctrl_pkg::SEL_STS;
        `IDX_BIPCLR: sel = chan_ctrl_pkg::SEL_CLR;
        default:     sel = chan_ctrl_pkg::SEL_NONE;
      endcase
    end
  end

  // zero wait states: read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = access && (sel == chan_ctrl_pkg::SEL_NONE);
  assign wr_en   = access && pwrite && wr_lane0 && ce;

  always_comb begin
    rd_word = `WORD_ZERO;
    case (sel)
      chan_ctrl_pkg::SEL_GEN:   rd_word = {24'h000000, gen_q};
      chan_ctrl_pkg::SEL_TST:   rd_word = {24'h000000, tst_q};
      chan_ctrl_pkg::SEL_RT:    rd_word = {24'h000000, rt_q};
      chan_ctrl_pkg::SEL_BIPEN: rd_word = {24'h000000, bipen_q};
      chan_ctrl_pkg::SEL_STS:   rd_word = {24'h000000, bip_status};
      // the clear register is write-only and the fifth word is empty
      default:                  rd_word = `WORD_ZERO;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= `WORD_ZERO;
    end else if (ce && setup) begin
      prdata_q <= pwrite ? `WORD_ZERO : rd_word;
    end
  end
  assign prdata = prdata_q;

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_q   <= `REG_RST;
      tst_q   <= `REG_RST;
      rt_q    <= `REG_RST;
      bipen_q <= `REG_RST;
    end else if (wr_en) begin
      // reserved positions are masked off on write
      case (sel)
        chan_ctrl_pkg::SEL_GEN:   gen_q   <= wbyte & `GEN_MASK;
        chan_ctrl_pkg::SEL_TST:   tst_q   <= wbyte & `TST_MASK;
        chan_ctrl_pkg::SEL_RT:    rt_q    <= wbyte & `RT_MASK;
        chan_ctrl_pkg::SEL_BIPEN: bipen_q <= wbyte & `BIPEN_MASK;
        default:                  bipen_q <= bipen_q;
      endcase
    end
  end

  assign bip_clr = (wr_en && (sel == chan_ctrl_pkg::SEL_CLR)) ? wbyte : `BYTE_ZERO;

  // ---------------------------------------------------------------
  // parity error interrupt
  // ---------------------------------------------------------------
  bip_irq u_irq (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .event_in (bip_error),
    .clear    (bip_clr),
    .enable   (bipen_q),
    .status   (bip_status),
    .irq      (irq)
  );

  // ---------------------------------------------------------------
  // transmit path
  // ---------------------------------------------------------------
  logic [7:0] tx_src;
  logic       tx_src_k;
  logic [7:0] tx_pre;
  logic       tx_pre_k;
  logic [7:0] tx_cond;
  logic [7:0] ser_tx_q;
  logic       ser_tx_k_q;
  logic [7:0] rx_q;
  logic       rx_k_q;

  assign tx_src   = rt_q[`RT_TC_TX] ? tc_tx_data_in : tx_data_in;
  assign tx_src_k = rt_q[`RT_TC_TX] ? tc_tx_k_in : tx_k_in;
  assign tx_pre   = gen_q[`GEN_FAB_LB] ? rx_q : tx_src;
  assign tx_pre_k = gen_q[`GEN_FAB_LB] ? rx_k_q : tx_src_k;

  bit_condition u_tx_cond (
    .data_in  (tx_pre),
    .reverse  (tst_q[`TST_TX_REV]),
    .invert   (tst_q[`TST_TX_INV]),
    .data_out (tx_cond)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_tx_q   <= `BYTE_ZERO;
      ser_tx_k_q <= 1'b0;
    end else if (ce) begin
      ser_tx_q   <= tx_cond;
      ser_tx_k_q <= tx_pre_k;
    end
  end
  assign ser_tx_data = ser_tx_q;
  assign ser_tx_k    = ser_tx_k_q;

  // ---------------------------------------------------------------
  // receive path
  // ---------------------------------------------------------------
  logic [7:0] rx_src;
  logic       rx_src_k;
  logic [7:0] rx_cond;
  logic [7:0] rx_out_d;
  logic       rx_k_d;
  logic       cv_d;
  logic       cv_q;
  logic [7:0] tc_rx_q;
  logic       tc_rx_k_q;

  // the serializer-side loop has no reset of its own; software must
  // reset the channel after toggling it or the aligner may be stale
  assign rx_src   = gen_q[`GEN_SER_LB] ? ser_tx_q : ser_rx_data;
  assign rx_src_k = gen_q[`GEN_SER_LB] ? ser_tx_k_q : ser_rx_k;

  bit_condition u_rx_cond (
    .data_in  (rx_src),
    .reverse  (tst_q[`TST_RX_REV]),
    .invert   (tst_q[`TST_RX_INV]),
    .data_out (rx_cond)
  );

  assign cv_d     = gen_q[`GEN_SOP] ? rx_sop_in : rx_cv_in;
  assign rx_out_d = (!gen_q[`GEN_SOP] && rx_cv_in) ? `CV_DATA : rx_cond;
  assign rx_k_d   = (!gen_q[`GEN_SOP] && rx_cv_in) ? 1'b1 : rx_src_k;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_q      <= `BYTE_ZERO;
      rx_k_q    <= 1'b0;
      cv_q      <= 1'b0;
      tc_rx_q   <= `BYTE_ZERO;
      tc_rx_k_q <= 1'b0;
    end else if (ce) begin
      rx_q      <= rx_out_d;
      rx_k_q    <= rx_k_d;
      cv_q      <= cv_d;
      // quad-level test mode must also be set by software
      tc_rx_q   <= rt_q[`RT_TC_RX] ? rx_out_d : `BYTE_ZERO;
      tc_rx_k_q <= rt_q[`RT_TC_RX] & rx_k_d;
    end
  end
  assign rx_data    = rx_q;
  assign rx_k       = rx_k_q;
  assign rx_cv_port = cv_q;
  assign tc_rx_data = tc_rx_q;
  assign tc_rx_k    = tc_rx_k_q;

  // ---------------------------------------------------------------
  // channel mode controls
  // ---------------------------------------------------------------
  logic crc_en_q;
  logic lsm_q;
  logic prbs_en_q;
  logic prbs_lock_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_en_q    <= 1'b1;
      lsm_q       <= 1'b0;
      prbs_en_q   <= 1'b0;
      prbs_lock_q <= 1'b0;
    end else if (ce) begin
      crc_en_q    <= !(gen_q[`GEN_CRC_DIS] && gen_q[`GEN_SOP]);
      lsm_q       <= gen_q[`GEN_LSM];
      prbs_en_q   <= tst_q[`TST_PRBS_EN];
      prbs_lock_q <= tst_q[`TST_PRBS_LOCK];
    end
  end
  assign crc_enable     = crc_en_q;
  assign link_sm_enable = lsm_q;
  assign prbs_enable    = prbs_en_q;
  assign prbs_lock      = prbs_lock_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_crc_disable: assert property (@(posedge pclk) disable iff (!presetn)
    ce && gen_q[`GEN_CRC_DIS] && gen_q[`GEN_SOP] |=> !crc_enable)
    else $error("crc logic not disabled in marker mode");

  a_crc_normal: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !gen_q[`GEN_CRC_DIS] |=> crc_enable)
    else $error("crc logic off without disable bit");

  a_cv_marker: assert property (@(posedge pclk) disable iff (!presetn)
    ce && gen_q[`GEN_SOP] |=> rx_cv_port == $past(rx_sop_in))
    else $error("violation port does not carry packet start");

  a_cv_code: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !gen_q[`GEN_SOP] && rx_cv_in |=> rx_cv_port && rx_k && rx_data == `CV_DATA)
    else $error("code violation not shown as k with ee");

  a_fab_loop: assert property (@(posedge pclk) disable iff (!presetn)
    ce && gen_q[`GEN_FAB_LB] && tst_q[7:4] == 4'h0 |=> ser_tx_data == $past(rx_data))
    else $error("fabric loopback not returning receive data");

  a_ser_loop: assert property (@(posedge pclk) disable iff (!presetn)
    ce && gen_q[`GEN_SER_LB] && !gen_q[`GEN_SOP] && !rx_cv_in && tst_q[7:4] == 4'h0
    |=> rx_data == $past(ser_tx_data))
    else $error("serializer loopback not feeding receive path");

  a_lsm_follow: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> link_sm_enable == $past(gen_q[`GEN_LSM]))
    else $error("link state machine enable does not follow its bit");

  a_prbs_both: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> prbs_enable == $past(tst_q[`TST_PRBS_EN]) && prbs_lock == $past(tst_q[`TST_PRBS_LOCK]))
    else $error("prbs controls do not follow their bits");

  a_tx_invert: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !gen_q[`GEN_FAB_LB] && !rt_q[`RT_TC_TX] && tst_q[`TST_TX_INV] && !tst_q[`TST_TX_REV]
    |=> ser_tx_data == ~$past(tx_data_in))
    else $error("transmit data not inverted");

  a_rx_reverse: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !gen_q[`GEN_SER_LB] && !gen_q[`GEN_SOP] && !rx_cv_in && tst_q[`TST_RX_REV] && !tst_q[`TST_RX_INV]
    |=> rx_data == chan_ctrl_pkg::byte_t'({<<{$past(ser_rx_data)}}))
    else $error("receive data not reversed");

  a_tc_rx_off: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !rt_q[`RT_TC_RX] |=> tc_rx_data == `BYTE_ZERO && !tc_rx_k)
    else $error("test pins active while routing off");

  a_tc_tx_src: assert property (@(posedge pclk) disable iff (!presetn)
    ce && rt_q[`RT_TC_TX] && !gen_q[`GEN_FAB_LB] && tst_q[7:4] == 4'h0
    |=> ser_tx_data == $past(tc_tx_data_in))
    else $error("transmit not sourced from test port");

  // an enabled error must raise the line one edge later unless the enables are being rewritten
  a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    ce && (bip_error & bipen_q) != `BYTE_ZERO && !(wr_en && sel == chan_ctrl_pkg::SEL_BIPEN) |=> irq)
    else $error("enabled parity error raised no interrupt");

  a_irq_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    ce && bip_error != `BYTE_ZERO |=> (bip_status & $past(bip_error)) == $past(bip_error))
    else $error("parity error flag lost");

  a_rsv_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (gen_q & ~`GEN_MASK) == `BYTE_ZERO && (tst_q & ~`TST_MASK) == `BYTE_ZERO
    && (rt_q & ~`RT_MASK) == `BYTE_ZERO)
    else $error("reserved bit set");

  a_rsv_read: assert property (@(posedge pclk) disable iff (!presetn)
    ce && setup && !pwrite && sel == chan_ctrl_pkg::SEL_RSV |=> prdata == `WORD_ZERO)
    else $error("reserved register reads nonzero");

  c_ser_loop:  cover property (@(posedge pclk) disable iff (!presetn) gen_q[`GEN_SER_LB]);
  c_fab_loop:  cover property (@(posedge pclk) disable iff (!presetn) gen_q[`GEN_FAB_LB]);
  c_irq_fire:  cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  c_sop_mode:  cover property (@(posedge pclk) disable iff (!presetn) gen_q[`GEN_SOP] && rx_sop_in);
endmodule
`default_nettype wire

// ---- bench/channel_general_control_regs_bench.sv ----
// self-checking bench for the channel control register bank
`timescale 1ns/10ps
`default_nettype none
`include "chan_ctrl_consts.svh"
module channel_general_control_regs_bench;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, errv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0]  pstrb;
  logic [7:0]  tx_data_in, tc_tx_data_in, ser_tx_data, ser_rx_data, rx_data, tc_rx_data, bip_error;
  logic        tx_k_in, tc_tx_k_in, ser_tx_k, ser_rx_k, rx_cv_in, rx_sop_in, rx_k, rx_cv_port, tc_rx_k;
  logic        crc_enable, link_sm_enable, prbs_enable, prbs_lock, irq;
  int          error_cnt, n_tests, cyc;

  chan_ctrl_regs uut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_data_in(tx_data_in), .tx_k_in(tx_k_in), .tc_tx_data_in(tc_tx_data_in), .tc_tx_k_in(tc_tx_k_in),
    .ser_tx_data(ser_tx_data), .ser_tx_k(ser_tx_k), .ser_rx_data(ser_rx_data), .ser_rx_k(ser_rx_k),
    .rx_cv_in(rx_cv_in), .rx_sop_in(rx_sop_in), .rx_data(rx_data), .rx_k(rx_k), .rx_cv_port(rx_cv_port),
    .tc_rx_data(tc_rx_data), .tc_rx_k(tc_rx_k), .crc_enable(crc_enable), .link_sm_enable(link_sm_enable),
    .prbs_enable(prbs_enable), .prbs_lock(prbs_lock), .bip_error(bip_error), .irq(irq)
  );

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask

  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction

  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7-i];
  endfunction

  // one apb transfer; never assumes a wait count, the loop guard only stops a hang
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) chk("pready", 32'h0000_0001, 32'h0000_0000);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    xfer(1'b1, ba(i), {24'h00_0000, d});
  endtask

  task automatic rd(input string nm, input logic [7:0] i, input logic [7:0] exp);
    xfer(1'b0, ba(i), 32'h0000_0000);
    chk(nm, {24'h00_0000, exp}, rdv);
  endtask

  // registered paths settle within three edges while inputs hold steady
  task automatic drv(input logic [7:0] t, input logic [7:0] r, input logic rk, input logic cv, input logic sp);
    @(posedge pclk);
    tx_data_in <= t;
    ser_rx_data <= r;
    ser_rx_k <= rk;
    rx_cv_in <= cv;
    rx_sop_in <= sp;
    repeat (3) @(posedge pclk);
    #1;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd("gen", `IDX_GEN, 8'h00);
    rd("tst", `IDX_TST, 8'h00);
    rd("rt", `IDX_RT, 8'h00);
    rd("bipen", `IDX_BIPEN, 8'h00);
    rd("rsv", `IDX_RSV4, 8'h00);
    chk("crc_rst", 32'h1, {31'h0, crc_enable});
    chk("lsm_rst", 32'h0, {31'h0, link_sm_enable});
  endtask

  task automatic t_masks;
    wr(`IDX_GEN, 8'hff);
    wr(`IDX_TST, 8'hff);
    wr(`IDX_RT, 8'hff);
    wr(`IDX_RSV4, 8'hff);
    rd("gen_m", `IDX_GEN, 8'hf8);
    rd("tst_m", `IDX_TST, 8'hf6);
    rd("rt_m", `IDX_RT, 8'hc0);
    rd("rsv_m", `IDX_RSV4, 8'h00);
    chk("crc_off", 32'h0, {31'h0, crc_enable});
    chk("lsm_on", 32'h1, {31'h0, link_sm_enable});
    chk("prbs_on", 32'h1, {31'h0, prbs_enable});
    chk("lock_on", 32'h1, {31'h0, prbs_lock});
    wr(`IDX_GEN, 8'h08);
    wr(`IDX_TST, 8'h02);
    @(posedge pclk);
    #1;
    chk("crc_nosop", 32'h1, {31'h0, crc_enable});
    chk("lsm_off", 32'h0, {31'h0, link_sm_enable});
    chk("lock_off", 32'h0, {31'h0, prbs_lock});
    wr(`IDX_TST, 8'h04);
    @(posedge pclk);
    #1;
    chk("prbs_off", 32'h0, {31'h0, prbs_enable});
    xfer(1'b0, 12'h014, 32'h0000_0000);
    chk("unmapped_err", 32'h1, {31'h0, errv});
    pstrb <= 4'he;
    wr(`IDX_GEN, 8'h80);
    pstrb <= 4'hf;
    ce <= 1'b0;
    wr(`IDX_GEN, 8'h80);
    ce <= 1'b1;
    rd("gen_kept", `IDX_GEN, 8'h08);
    wr(`IDX_GEN, 8'h00);
    wr(`IDX_TST, 8'h00);
  endtask

  // every reverse and invert combination on both directions at once
  task automatic t_cond;
    logic [7:0] e;
    wr(`IDX_RT, 8'h40);
    for (int m = 0; m < 4; m++) begin
      wr(`IDX_TST, {m[1], m[0], m[1], m[0], 4'h0});
      drv(8'h1c, 8'h1c, 1'b1, 1'b0, 1'b0);
      e = m[0] ? rev(8'h1c) : 8'h1c;
      e = m[1] ? ~e : e;
      chk("ser_tx_data", {24'h0, e}, {24'h0, ser_tx_data});
      chk("rx_data", {24'h0, e}, {24'h0, rx_data});
      chk("tc_rx_data", {24'h0, e}, {24'h0, tc_rx_data});
      chk("rx_k", 32'h1, {31'h0, rx_k});
      chk("tc_rx_k", 32'h1, {31'h0, tc_rx_k});
    end
    wr(`IDX_TST, 8'h00);
    wr(`IDX_RT, 8'h80);
    tc_tx_data_in <= 8'h5a;
    tc_tx_k_in <= 1'b1;
    drv(8'h11, 8'h22, 1'b0, 1'b0, 1'b0);
    chk("tc_tx", 32'h5a, {24'h0, ser_tx_data});
    chk("tc_tx_k", 32'h1, {31'h0, ser_tx_k});
    chk("tc_rx_off", 32'h0, {24'h0, tc_rx_data});
    chk("tc_rx_k_off", 32'h0, {31'h0, tc_rx_k});
    wr(`IDX_RT, 8'h00);
    drv(8'h11, 8'h22, 1'b0, 1'b0, 1'b0);
    chk("fabric_tx", 32'h11, {24'h0, ser_tx_data});
    chk("fabric_tx_k", 32'h0, {31'h0, ser_tx_k});
  endtask

  task automatic t_cv;
    drv(8'h00, 8'h33, 1'b0, 1'b1, 1'b0);
    chk("cv_data", 32'hee, {24'h0, rx_data});
    chk("cv_k", 32'h1, {31'h0, rx_k});
    chk("cv_port", 32'h1, {31'h0, rx_cv_port});
    wr(`IDX_GEN, 8'h10);
    drv(8'h00, 8'h33, 1'b0, 1'b0, 1'b1);
    chk("sop_port", 32'h1, {31'h0, rx_cv_port});
    drv(8'h00, 8'h33, 1'b0, 1'b1, 1'b0);
    chk("sop_nocv", 32'h0, {31'h0, rx_cv_port});
    chk("sop_data", 32'h33, {24'h0, rx_data});
    wr(`IDX_GEN, 8'h00);
  endtask

  task automatic t_loop;
    wr(`IDX_GEN, 8'h20);
    drv(8'h11, 8'h96, 1'b0, 1'b0, 1'b0);
    chk("fab_lb", 32'h96, {24'h0, ser_tx_data});
    wr(`IDX_GEN, 8'h40);
    drv(8'h3c, 8'h81, 1'b0, 1'b0, 1'b0);
    chk("ser_lb", 32'h3c, {24'h0, rx_data});
    wr(`IDX_GEN, 8'h00);
    // the channel is reset after the serializer loop is switched off
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rd("gen_rst", `IDX_GEN, 8'h00);
    drv(8'h3c, 8'h81, 1'b0, 1'b0, 1'b0);
    chk("lb_off", 32'h81, {24'h0, rx_data});
  endtask

  task automatic t_irq;
    wr(`IDX_BIPEN, 8'h00);
    @(posedge pclk);
    bip_error <= 8'h84;
    @(posedge pclk);
    bip_error <= 8'h00;
    rd("sts", `IDX_BIPSTS, 8'h84);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(`IDX_BIPEN, 8'h08);
    #1;
    chk("irq_other", 32'h0, {31'h0, irq});
    wr(`IDX_BIPEN, 8'h04);
    #1;
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(`IDX_BIPCLR, 8'h04);
    rd("sts_clr", `IDX_BIPSTS, 8'h80);
    chk("irq_clr", 32'h0, {31'h0, irq});
    rd("clr_rd", `IDX_BIPCLR, 8'h00);
    @(posedge pclk);
    bip_error <= 8'h04;
    @(posedge pclk);
    bip_error <= 8'h00;
    @(posedge pclk);
    #1;
    chk("irq_set", 32'h1, {31'h0, irq});
  endtask

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      wrap_up();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, tx_k_in, tc_tx_k_in, ser_rx_k, rx_cv_in, rx_sop_in} = '0;
    {paddr, pwdata, tx_data_in, tc_tx_data_in, ser_rx_data, bip_error} = '0;
    ce = 1'b1;
    pstrb = 4'hf;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_masks();
    t_cond();
    t_cv();
    t_loop();
    t_irq();
    wrap_up();
  end
endmodule
`default_nettype wire
